/* core/smpp_pkg.sv */
// Purpose: shared constants for the serial memory programming port
// Assumes: mclk at 40 MHz; memories are small models held inside the port
// Notes: opcodes are the first instruction byte of each four-byte frame
package smpp_pkg;
   localparam int MCLK_HZ = 40000000;
   localparam int FIFO_W = 32;
   localparam int FIFO_D = 32;
   // memory geometry, reduced array sizes
   localparam int FL_AW = 15;          // flash word address bits
   localparam int PG_AW = 7;           // word bits within a page
   localparam int EE_AW = 11;          // eeprom byte address bits
   localparam logic [7:0] ERASED = 8'hff;
   localparam logic [7:0] ECHO_BYTE = 8'h53;
   localparam logic [7:0] OP_ENABLE = 8'hac;
   localparam logic [7:0] OP_RD_FL = 8'h20;
   localparam logic [7:0] OP_LD_PG = 8'h40;
   localparam logic [7:0] OP_WR_PG = 8'h4c;
   localparam logic [7:0] OP_RD_EE = 8'ha0;
   localparam logic [7:0] OP_WR_EE = 8'hc0;
   localparam logic [2:0] SUB_ERASE = 3'h4;   // byte 2 top bits 100
   localparam int HI_BIT = 3;                 // position of H in byte 1
   localparam int FRAME_BITS = 32;
   // self-timed write times in microseconds
   localparam int T_FLASH_US = 4500;
   localparam int T_EEPROM_US = 9000;
   localparam int T_ERASE_US = 9000;
   localparam int FLASH_CYC_DEF = T_FLASH_US * (MCLK_HZ / 1000000);
   localparam int EEPROM_CYC_DEF = T_EEPROM_US * (MCLK_HZ / 1000000);
   localparam int ERASE_CYC_DEF = T_ERASE_US * (MCLK_HZ / 1000000);
   typedef enum logic [1:0] {SMPP_IDLE, SMPP_FLASH, SMPP_EEPROM, SMPP_ERASE} smpp_busy_e;
endpackage

/* core/smpp_fifo.sv */
// Purpose: frame fifo between serial shifter and command executor
// Assumes: single clock, synchronous active low reset
// Notes: full and empty are exact; writer must honour in_ready
`timescale 1ns/1ps
`default_nettype none
module smpp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic mclk,               // clock
   input wire logic rst_n,              // sync reset
   input wire logic in_valid,           // write request
   output logic in_ready,               // not full
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid,              // not empty
   input wire logic out_ready,          // read accept
   output logic [WIDTH-1:0] out_data    // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, rp_q;
   logic [AW:0] cnt_q;
   logic push, pop;
   assign in_ready = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rp_q];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   // storage has no reset, only pointers do
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end
   // pointers and fill count
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

/* core/smpp_port.sv */
// Purpose: serial in-system programming port for program flash and eeprom
// Assumes: sck slower than mclk per phase limits; mclk present when used
// Notes: flash and eeprom are held here as arrays; clock is sampled, not used
// How it works
// - programming only while reset_n low or strap caught, enable frame needed first
// - serial input bits taken at each sampled rising sck edge
// - serial output bit changes at each sampled falling sck edge
// - port logic runs only from the present cpu clock
// - mode select pin caught once at power-on; stays until power cycle
// - echo 0x53 while third enable byte shifts in
// - load-page puts one byte at 7-bit word offset into buffer
// - write-page commits buffer to page given by 8 upper bits
// - eeprom write stores one byte at given address
// - eeprom byte write erases location first, self-timed
// - chip erase sets all flash and eeprom to 0xff
// - read frames shift stored content out in fourth byte
// - reset_n high ends the session unless the strap was caught at power-on
// - dedicated serial in and out pins, shared clock pin
// - enable frame is 0xac, 0x53, two don't-care bytes
// - reads in the page under programming return 0xff
`timescale 1ns/1ps
`default_nettype none
module smpp_port import smpp_pkg::*; #(
   parameter int FLASH_CYC = FLASH_CYC_DEF,
   parameter int EEPROM_CYC = EEPROM_CYC_DEF,
   parameter int ERASE_CYC = ERASE_CYC_DEF
) (
   input wire logic mclk,               // cpu clock
   input wire logic rst_n,              // sync reset, power-on
   input wire logic reset_pin_n,        // device reset pin
   input wire logic prog_mode_select_n, // mode select strap pin
   input wire logic sck,                // shared serial clock pin
   input wire logic prog_serial_in,     // serial data in
   output logic prog_serial_out,        // serial data out
   output logic prog_active,            // session enabled
   output logic prog_busy,              // self-timed write running
   output logic cpu_run                 // normal operation allowed
);

   // two-flop synchronisers for all pins
   logic [1:0] sck_s, sdi_s, rst_s, pen_s;
   logic sck_prev_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sck_s <= '0;
         sdi_s <= '0;
         rst_s <= '0;
         pen_s <= 2'h3;
         sck_prev_q <= 1'b0;
      end else begin
         sck_s <= {sck_s[0], sck};
         sdi_s <= {sdi_s[0], prog_serial_in};
         rst_s <= {rst_s[0], reset_pin_n};
         pen_s <= {pen_s[0], prog_mode_select_n};
         sck_prev_q <= sck_s[1];
      end
   end
   logic sck_rise, sck_fall, in_reset;
   assign sck_rise = sck_s[1] && !sck_prev_q;
   assign sck_fall = !sck_s[1] && sck_prev_q;

   // strap is caught on the first cycles after power-on release
   logic [1:0] por_cnt_q;
   logic pen_mode_q;
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         por_cnt_q <= '0;
         pen_mode_q <= 1'b0;
      end else if (por_cnt_q != 2'h3) begin
         por_cnt_q <= por_cnt_q + 2'h1;
         if (por_cnt_q == 2'h2) pen_mode_q <= !pen_s[1];
      end
   end
   assign in_reset = !rst_s[1] || pen_mode_q;

   // shift register and frame bit counter
   logic [31:0] shin_q;
   logic [4:0] bit_q;
   logic [7:0] shout_q;
   logic frame_done;
   assign frame_done = sck_rise && (bit_q == 5'(FRAME_BITS - 1));
   always_ff @(posedge mclk) begin
      if (!rst_n || !in_reset) begin
         shin_q <= '0;
         bit_q <= '0;
      end else if (sck_rise) begin
         shin_q <= {shin_q[30:0], sdi_s[1]};
         bit_q <= bit_q + 5'h1;
      end
   end

   // frames queue up for the executor
   logic f_in_ready, f_valid, f_pop;
   logic [31:0] f_data;
   smpp_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
      .mclk(mclk),
      .rst_n(rst_n && in_reset),
      .in_valid(frame_done),
      .in_ready(f_in_ready),
      .in_data({shin_q[30:0], sdi_s[1]}),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // memories
   logic [7:0] flash_lo [2**FL_AW];
   logic [7:0] flash_hi [2**FL_AW];
   logic [7:0] eeprom [2**EE_AW];
   logic [7:0] buf_lo [2**PG_AW];
   logic [7:0] buf_hi [2**PG_AW];

   // enable, busy timer and commit state
   logic enabled_q;
   smpp_busy_e busy_q;
   logic [31:0] tmr_q;
   logic [FL_AW-PG_AW-1:0] page_q;
   logic [PG_AW:0] wi_q;
   logic [EE_AW-1:0] eaddr_q;
   logic [7:0] edata_q;
   logic [FL_AW:0] ei_q;
   logic [7:0] op, b2, b3, b4;
   logic sweep_open;
   assign op = f_data[31:24];
   assign b2 = f_data[23:16];
   assign b3 = f_data[15:8];
   assign b4 = f_data[7:0];
   // a sweep still open keeps busy up even when the timer has run out
   assign sweep_open = (busy_q == SMPP_ERASE && !ei_q[FL_AW]) ||
      (busy_q == SMPP_FLASH && !wi_q[PG_AW]);

   // frames are taken only when no write is in flight
   assign f_pop = f_valid && (busy_q == SMPP_IDLE);
   function automatic logic in_page(input logic [FL_AW-1:0] a,
                                    input logic [FL_AW-PG_AW-1:0] p);
      in_page = (a[FL_AW-1:PG_AW] == p);
   endfunction
   always_ff @(posedge mclk) begin
      if (!rst_n || !in_reset) begin
         enabled_q <= 1'b0;
      end else if (f_pop && op == OP_ENABLE && b2 == ECHO_BYTE) begin
         enabled_q <= 1'b1;
      end
   end

   // executor: writes start self-timed operations
   always_ff @(posedge mclk) begin
      if (!rst_n || !in_reset) begin
         busy_q <= SMPP_IDLE;
         tmr_q <= '0;
         page_q <= '0;
         wi_q <= '0;
         eaddr_q <= '0;
         edata_q <= ERASED;
         ei_q <= '0;
      end else if (busy_q != SMPP_IDLE) begin
         if (tmr_q != '0) tmr_q <= tmr_q - 32'h1;
         if (busy_q == SMPP_FLASH && !wi_q[PG_AW]) begin
            flash_lo[{page_q, wi_q[PG_AW-1:0]}] <= buf_lo[wi_q[PG_AW-1:0]];
            flash_hi[{page_q, wi_q[PG_AW-1:0]}] <= buf_hi[wi_q[PG_AW-1:0]];
            wi_q <= wi_q + 1'b1;
         end
         if (busy_q == SMPP_ERASE && !ei_q[FL_AW]) begin
            flash_lo[ei_q[FL_AW-1:0]] <= ERASED;
            flash_hi[ei_q[FL_AW-1:0]] <= ERASED;
            eeprom[ei_q[EE_AW-1:0]] <= ERASED;
            ei_q <= ei_q + 1'b1;
         end
         if (busy_q == SMPP_EEPROM) begin
            // erase then write inside one self-timed slot
            eeprom[eaddr_q] <= (tmr_q > 32'(EEPROM_CYC / 2)) ? ERASED : edata_q;
         end
         // timer sets the minimum time, an open sweep holds busy until it is done
         if (tmr_q <= 32'h1 && !sweep_open) busy_q <= SMPP_IDLE;
      end else if (f_pop && enabled_q) begin
         unique case (op)
            OP_LD_PG, OP_LD_PG | 8'(1 << HI_BIT): begin
               if (op[HI_BIT]) buf_hi[b3[PG_AW-1:0]] <= b4;
               else buf_lo[b3[PG_AW-1:0]] <= b4;
            end
            OP_WR_PG: begin
               page_q <= {b2[FL_AW-9:0], b3[7]};
               wi_q <= '0;
               busy_q <= SMPP_FLASH;
               tmr_q <= 32'(FLASH_CYC);
            end
            OP_WR_EE: begin
               eaddr_q <= {b2[EE_AW-9:0], b3};
               edata_q <= b4;
               busy_q <= SMPP_EEPROM;
               tmr_q <= 32'(EEPROM_CYC);
            end
            OP_ENABLE: begin
               if (b2[7:5] == SUB_ERASE) begin
                  ei_q <= '0;
                  busy_q <= SMPP_ERASE;
                  tmr_q <= 32'(ERASE_CYC);
               end
            end
            default: begin
            end
         endcase
      end
   end

   // read data for the fourth byte, decoded from the live shift register
   // the load comes on the 24th rise, so the last address bit is still in the synchroniser
   logic [7:0] rd_byte;
   logic [FL_AW-1:0] rd_fa;
   logic [23:0] rd_hdr;
   logic rd_fl_op;
   assign rd_hdr = {shin_q[22:0], sdi_s[1]};
   assign rd_fa = rd_hdr[FL_AW-1:0];
   assign rd_fl_op = (rd_hdr[23:16] == OP_RD_FL) || (rd_hdr[23:16] == (OP_RD_FL | 8'(1 << HI_BIT)));
   always_comb begin
      rd_byte = '0;
      if (rd_fl_op) begin
         if (busy_q == SMPP_FLASH && in_page(rd_fa, page_q)) rd_byte = ERASED;
         else rd_byte = rd_hdr[16+HI_BIT] ? flash_hi[rd_fa] : flash_lo[rd_fa];
      end else if (rd_hdr[23:16] == OP_RD_EE) begin
         rd_byte = eeprom[rd_hdr[EE_AW-1:0]];
      end
   end

   // output shifter, loaded at byte boundaries, moved on falling edges
   always_ff @(posedge mclk) begin
      if (!rst_n || !in_reset) begin
         shout_q <= '0;
         prog_serial_out <= 1'b0;
      end else if (sck_rise && bit_q[2:0] == 3'h7) begin
         // byte 2 echoes back during byte 3
         if (bit_q == 5'h0f) shout_q <= {shin_q[6:0], sdi_s[1]};
         else if (bit_q == 5'h17 && enabled_q) shout_q <= rd_byte;
         else shout_q <= '0;
      end else if (sck_fall) begin
         prog_serial_out <= shout_q[7];
         shout_q <= {shout_q[6:0], 1'b0};
      end
   end

   // status pins
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         prog_active <= 1'b0;
         prog_busy <= 1'b0;
         cpu_run <= 1'b0;
      end else begin
         prog_active <= enabled_q && in_reset;
         prog_busy <= busy_q != SMPP_IDLE;
         cpu_run <= !in_reset;
      end
   end

   // fifo only fills if the programmer sends more than polls during a long write
   logic unused_ok;
   assign unused_ok = f_in_ready;

   AST_ECHO: assert property (@(posedge mclk) disable iff (!rst_n)
      (sck_rise && bit_q == 5'h0f && in_reset) |=> shout_q == $past({shin_q[6:0], sdi_s[1]}))
      else $error("echo not loaded");

   AST_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
      !sck_fall |=> $stable(prog_serial_out))
      else $error("data out moved off falling edge");

   AST_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
      !in_reset |=> !prog_active)
      else $error("session kept after reset high");

   AST_NOEN: assert property (@(posedge mclk) disable iff (!rst_n)
      (!enabled_q && busy_q == SMPP_IDLE) |=> busy_q == SMPP_IDLE)
      else $error("write started before enable");

   AST_BUSY: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      (f_pop && enabled_q && op == OP_WR_PG) |=> busy_q == SMPP_FLASH)
      else $error("page write not started");

   AST_STRAP: assert property (@(posedge mclk) disable iff (!rst_n)
      (por_cnt_q == 2'h3) |=> $stable(pen_mode_q))
      else $error("strap changed after power-on");

   AST_SHIFT: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      sck_rise |=> shin_q[0] == $past(sdi_s[1]))
      else $error("input bit not taken");

   AST_EEW: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      (f_pop && enabled_q && op == OP_WR_EE) |=> busy_q == SMPP_EEPROM && edata_q == $past(b4))
      else $error("eeprom write not started");

   // steps shared by the multi-step checks below
   sequence s_erase_sweep;
      busy_q == SMPP_ERASE && !ei_q[FL_AW];
   endsequence
   sequence s_page_sweep;
      busy_q == SMPP_FLASH && !wi_q[PG_AW];
   endsequence
   sequence s_enable_taken;
      f_pop && op == OP_ENABLE && b2 == ECHO_BYTE;
   endsequence
   sequence s_poll_in_page;
      sck_rise && bit_q == 5'h17 && enabled_q && rd_fl_op &&
         busy_q == SMPP_FLASH && in_page(rd_fa, page_q);
   endsequence

   AST_SWEEP: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      s_erase_sweep |=> busy_q == SMPP_ERASE)
      else $error("erase ended before every cell was cleared");

   AST_PAGE: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      s_page_sweep |=> busy_q == SMPP_FLASH)
      else $error("page write ended before the buffer was copied");

   AST_ENTER: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      s_enable_taken |=> enabled_q)
      else $error("enable frame not accepted");

   AST_POLL: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      s_poll_in_page |=> shout_q == ERASED)
      else $error("page under write did not read as erased");

   AST_OUT: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      sck_fall |=> prog_serial_out == $past(shout_q[7]))
      else $error("falling edge did not move the next bit out");

   AST_FRAME: assert property (@(posedge mclk) disable iff (!rst_n || !in_reset)
      frame_done |=> bit_q == 5'h00)
      else $error("bit counter not back at frame start");

   AST_BUSYPIN: assert property (@(posedge mclk) disable iff (!rst_n)
      (busy_q != SMPP_IDLE) |=> prog_busy)
      else $error("busy pin low during a write");

   AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
      in_reset |=> !cpu_run)
      else $error("cpu runs while reset pin is low");
endmodule
`default_nettype wire

/* testbench/smpp_prog_model.sv */
// Purpose: behavioural in-system programmer that drives four-byte serial frames
// Assumes: sck half period of 100 ns, four mclk cycles at 40 MHz
// Notes: power-up wait shortened; the real programmer waits far longer
`timescale 1ns/1ps
`default_nettype none
module smpp_prog_model import smpp_pkg::*; #(
   parameter int HALF_NS = 100,
   parameter int PWR_WAIT_NS = 2000
) (
   output logic reset_pin_n,     // device reset pin
   output logic sck,             // serial clock, still between frames
   output logic prog_serial_in,  // data towards the device
   input wire logic prog_serial_out // data from the device
);
   // power-up with reset and clock both low
   initial begin
      reset_pin_n = 1'b0;
      sck = 1'b0;
      prog_serial_in = 1'b1;
   end

   // one whole frame, msb first, data set while sck is low
   task automatic xfer(input logic [31:0] f, output logic [31:0] rx);
      for (int i = 31; i >= 0; i--) begin
         prog_serial_in = f[i];
         #HALF_NS;
         sck = 1'b1;
         rx = {rx[30:0], prog_serial_out};
         #HALF_NS;
         sck = 1'b0;
      end
      // released line shows the inverse so a stale value cannot pass
      prog_serial_in = ~f[0];
      // idle gap so back-to-back frames never assign data twice in one step
      #HALF_NS;
   endtask

   task automatic set_reset(input logic v);
      reset_pin_n = v;
   endtask

   // enable frame, resent once after a reset pulse if the echo is missing
   task automatic enable(output logic [7:0] echo);
      logic [31:0] rx;
      #PWR_WAIT_NS;
      xfer({OP_ENABLE, ECHO_BYTE, 16'h0000}, rx);
      echo = rx[15:8];
      if (echo !== ECHO_BYTE) begin
         reset_pin_n = 1'b1;
         #(4 * HALF_NS);
         reset_pin_n = 1'b0;
         #PWR_WAIT_NS;
         xfer({OP_ENABLE, ECHO_BYTE, 16'h0000}, rx);
         echo = rx[15:8];
      end
   endtask

   // one page word, low byte always before high byte
   task automatic load_word(input logic [6:0] off, input logic [15:0] w);
      logic [31:0] rx;
      xfer({OP_LD_PG, 8'h00, 1'b0, off, w[7:0]}, rx);
      xfer({OP_LD_PG | 8'h08, 8'h00, 1'b0, off, w[15:8]}, rx);
   endtask
endmodule
`default_nettype wire

/* testbench/smpp_port_tb.sv */
// Purpose: self-checking bench for the serial programming port
// Assumes: write times cut to BUSY_CYC cycles; chip erase sweeps one cell a cycle
// Notes: memory content is only trusted after a chip erase
`timescale 1ns/1ps
`default_nettype none
module smpp_port_tb import smpp_pkg::*;;
   localparam int BUSY_CYC = 2000;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic prog_mode_select_n = 1'b1;
   logic reset_pin_n, sck, prog_serial_in;
   logic prog_serial_out, prog_active, prog_busy, cpu_run;
   logic [7:0] d;
   logic [31:0] rx;
   int bad_count = 0;
   int total_checks = 0;

   always #12.5 mclk = ~mclk;

   smpp_port #(.FLASH_CYC(BUSY_CYC), .EEPROM_CYC(BUSY_CYC), .ERASE_CYC(BUSY_CYC)) uut (
      .mclk(mclk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
      .prog_mode_select_n(prog_mode_select_n), .sck(sck), .prog_serial_in(prog_serial_in),
      .prog_serial_out(prog_serial_out), .prog_active(prog_active), .prog_busy(prog_busy),
      .cpu_run(cpu_run));

   smpp_prog_model u_prog (
      .reset_pin_n(reset_pin_n), .sck(sck), .prog_serial_in(prog_serial_in),
      .prog_serial_out(prog_serial_out));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #3;
   endtask

   // busy must rise after a write and fall within a bounded wait
   task automatic wait_idle(input int lim);
      int n;
      tick(12);
      check({7'h0, prog_busy}, 8'h01, "busy after write");
      n = 0;
      while (prog_busy !== 1'b0 && n < lim) begin
         tick(1);
         n++;
      end
      check({7'h0, prog_busy}, 8'h00, "busy ends");
   endtask

   task automatic rd(input logic [7:0] op, input logic [15:0] adr, output logic [7:0] v);
      logic [31:0] r;
      u_prog.xfer({op, adr, 8'h00}, r);
      v = r[7:0];
   endtask

   task automatic t_enable();
      check({7'h0, prog_active}, 8'h00, "inactive at start");
      check({7'h0, cpu_run}, 8'h00, "cpu held");
      u_prog.xfer({OP_RD_FL, 16'h0000, 8'h00}, rx);
      tick(8);
      check({7'h0, prog_active}, 8'h00, "read before enable");
      u_prog.enable(d);
      check(d, ECHO_BYTE, "echo");
      tick(8);
      check({7'h0, prog_active}, 8'h01, "active");
      $display("test enable done");
   endtask

   task automatic t_erase();
      u_prog.xfer({OP_ENABLE, 8'h80, 16'h0000}, rx);
      wait_idle(2 * (2 ** FL_AW));
      rd(OP_RD_FL, 16'h0000, d);
      check(d, ERASED, "flash low erased");
      rd(OP_RD_FL | 8'h08, 16'h7fff, d);
      check(d, ERASED, "flash high erased");
      rd(OP_RD_EE, 16'h07ff, d);
      check(d, ERASED, "eeprom erased");
      $display("test erase done");
   endtask

   task automatic t_session();
      u_prog.set_reset(1'b1);
      tick(10);
      check({7'h0, cpu_run}, 8'h01, "run after session");
      check({7'h0, prog_active}, 8'h00, "session closed");
      u_prog.set_reset(1'b0);
      tick(10);
      u_prog.xfer({OP_WR_EE, 16'h0010, 8'h3c}, rx);
      tick(20);
      check({7'h0, prog_busy}, 8'h00, "write refused");
      u_prog.enable(d);
      rd(OP_RD_EE, 16'h0010, d);
      check(d, ERASED, "refused write left cell");
      $display("test session done");
   endtask

   task automatic t_eeprom();
      u_prog.xfer({OP_WR_EE, 16'h07ff, 8'h5a}, rx);
      wait_idle(4 * BUSY_CYC);
      rd(OP_RD_EE, 16'h07ff, d);
      check(d, 8'h5a, "eeprom first");
      u_prog.xfer({OP_WR_EE, 16'h07ff, 8'ha5}, rx);
      rd(OP_RD_EE, 16'h07ff, d);
      check(d, ERASED, "eeprom erased first");
      wait_idle(4 * BUSY_CYC);
      rd(OP_RD_EE, 16'h07ff, d);
      check(d, 8'ha5, "eeprom overwrite");
      $display("test eeprom done");
   endtask

   task automatic t_flash();
      logic [7:0] pg;
      pg = 8'h12;
      u_prog.load_word(7'h7f, 16'hbeef);
      u_prog.load_word(7'h00, 16'h1234);
      u_prog.xfer({OP_WR_PG, 1'b0, pg[7:1], pg[0], 7'h00, 8'h00}, rx);
      tick(12);
      check({7'h0, prog_busy}, 8'h01, "page busy");
      rd(OP_RD_FL, {1'b0, pg, 7'h7f}, d);
      check(d, ERASED, "page read while busy");
      wait_idle(4 * BUSY_CYC);
      rd(OP_RD_FL, {1'b0, pg, 7'h7f}, d);
      check(d, 8'hef, "top word low");
      rd(OP_RD_FL | 8'h08, {1'b0, pg, 7'h7f}, d);
      check(d, 8'hbe, "top word high");
      rd(OP_RD_FL | 8'h08, {1'b0, pg, 7'h00}, d);
      check(d, 8'h12, "first word high");
      rd(OP_RD_FL, {1'b0, pg + 8'h01, 7'h00}, d);
      check(d, ERASED, "next page untouched");
      $display("test flash done");
   endtask

   task automatic t_strap();
      rst_n = 1'b0;
      prog_mode_select_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(6);
      prog_mode_select_n = 1'b1;
      u_prog.set_reset(1'b1);
      tick(10);
      check({7'h0, cpu_run}, 8'h00, "strap keeps mode");
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(10);
      check({7'h0, cpu_run}, 8'h01, "power cycle frees");
      $display("test strap done");
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // watchdog: the chip erase sweep dominates, the whole run needs about 1.2 ms
   initial begin
      #2000000;
      bad_count++;
      $display("ERROR at %0t: watchdog expired", $time);
      report_and_stop();
   end

   initial begin
      tick(2);
      rst_n = 1'b1;
      tick(6);
      t_enable();
      t_erase();
      t_session();
      t_eeprom();
      t_flash();
      t_strap();
      report_and_stop();
   end
endmodule
`default_nettype wire
